// ==== core/mode_control_regs.sv ====
// Purpose: APB bank of monitor gains and playback-only controls driving analog lines.
// Assumes: Operating mode is written by software into a mode select register.
// Notes: Writes are not gated; outputs other than gain_code_reserved are gated by the active operating mode.
// Overview of operation
// - Gain is code times half decibel.
// - Mute code depends on attenuation setting.
// - Right gain mirrors left gain coding.
// - Playback-only enable bit, resets to one.
// - Line input mute bit, resets zero.
// - Left opamp one enable bit.
// - Right opamp one enable bit.
// - Headphone amp enable; clear closes bypass.
// - Charge pump bypass enable bit.
// - Supply regulator enable, resets to one.
// - Pump enable; clear activates bypass switch.
// - Preamplifier enable bit, resets zero.
// - Headphone source select, resets to 11.
// - Source codes: preamp, opamp, reserved, line.
//
// The APB register port was decided locally.
`include "regbank_consts.svh"
module mode_control_regs #(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic negative_attenuation_enable,
  output logic [6:0] monitor_left_gain_code,
  output logic [6:0] monitor_right_gain_code,
  output logic monitor_left_mute,
  output logic monitor_right_mute,
  output logic playback_line_input_mute,
  output logic playback_left_opamp_enable,
  output logic playback_right_opamp_enable,
  output logic headphone_amp_enable,
  output logic music_bypass_switch_on,
  output logic supply_pump_bypass_enable,
  output logic mic_supply_regulator_enable,
  output logic mic_supply_pump_enable,
  output logic mic_preamp_enable,
  output logic [1:0] headphone_source_select,
  output logic gain_code_reserved
);
  if (ADDR_WIDTH < 11 || ADDR_WIDTH > 32)
  begin
    $error("ADDR_WIDTH must lie between 11 and 32");
  end

  logic [7:0] mon_left_r;
  logic [7:0] mon_right_r;
  logic [7:0] pbo_a_r;
  logic [7:0] pbo_b_r;
  logic [7:0] mode_sel_r;
  logic [6:0] left_steps;
  logic [6:0] right_steps;
  logic left_mute;
  logic right_mute;
  logic left_rsv;
  logic right_rsv;
  logic in_monitor;
  logic in_playback;
  logic pbo_on;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [7:0] idx;
  logic [7:0] rd_val;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] wd,
                                       input logic [3:0] be, input logic [7:0] mask);
    merge = be[0] ? (wd[7:0] & mask) : old;
  endfunction

  assign idx = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[ADDR_WIDTH-1:10] == '0);
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;

  always_comb
  begin
    pslverr = 1'b0;
    rd_val = 8'h00;
    if (!addr_ok)
    begin
      pslverr = psel && penable;
    end
    else if (idx == `IDX_MON_LEFT_GAIN)
    begin
      rd_val = mon_left_r;
    end
    else if (idx == `IDX_MON_RIGHT_GAIN)
    begin
      rd_val = mon_right_r;
    end
    else if (idx == `IDX_PBO_CTRL_A)
    begin
      rd_val = pbo_a_r;
    end
    else if (idx == `IDX_PBO_CTRL_B)
    begin
      rd_val = pbo_b_r;
    end
    else if (idx == `IDX_MODE_SELECT)
    begin
      rd_val = mode_sel_r;
    end
    else
    begin
      pslverr = psel && penable;
    end
  end

  // Gain registers store the code as written; the reserved code is flagged and decodes to zero steps.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mon_left_r <= `RST_MON_LEFT_GAIN;
      mon_right_r <= `RST_MON_RIGHT_GAIN;
    end
    else if (wr_en && addr_ok)
    begin
      if (idx == `IDX_MON_LEFT_GAIN)
      begin
        mon_left_r <= merge(mon_left_r, pwdata, pstrb, `MASK_GAIN);
      end
      else if (idx == `IDX_MON_RIGHT_GAIN)
      begin
        mon_right_r <= merge(mon_right_r, pwdata, pstrb, `MASK_GAIN);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pbo_a_r <= `RST_PBO_CTRL_A;
      pbo_b_r <= `RST_PBO_CTRL_B;
    end
    else if (wr_en && addr_ok)
    begin
      if (idx == `IDX_PBO_CTRL_A)
      begin
        pbo_a_r <= merge(pbo_a_r, pwdata, pstrb, `MASK_PBO_CTRL_A);
      end
      else if (idx == `IDX_PBO_CTRL_B)
      begin
        pbo_b_r <= merge(pbo_b_r, pwdata, pstrb, `MASK_PBO_CTRL_B);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_sel_r <= `RST_MODE_SELECT;
    end
    else if (wr_en && addr_ok && idx == `IDX_MODE_SELECT)
    begin
      mode_sel_r <= merge(mode_sel_r, pwdata, pstrb, `MASK_MODE_SELECT);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    // Loaded at the end of the setup cycle, so the word already stands at the access edge.
    else if (rd_en)
    begin
      prdata <= {24'h00_0000, rd_val};
    end
  end

  gain_decode left_dec (
    .code(mon_left_r[6:0]),
    .negative_attenuation_enable(negative_attenuation_enable),
    .half_db_steps(left_steps),
    .mute(left_mute),
    .reserved_code(left_rsv)
  );

  gain_decode right_dec (
    .code(mon_right_r[6:0]),
    .negative_attenuation_enable(negative_attenuation_enable),
    .half_db_steps(right_steps),
    .mute(right_mute),
    .reserved_code(right_rsv)
  );

  // A reserved mode select value selects neither mode, so lines rest off, the source select at line only, and gain_code_reserved still flags.
  assign in_monitor = (mode_sel_r[1:0] == regbank_pkg::MODE_MONITOR);
  assign in_playback = (mode_sel_r[1:0] == regbank_pkg::MODE_PLAYBACK);
  assign pbo_on = in_playback && pbo_a_r[`BIT_PBO_ENABLE];

  // Outputs are registered so the analog lines never see decode glitches.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      monitor_left_gain_code <= 7'h00;
      monitor_right_gain_code <= 7'h00;
      monitor_left_mute <= 1'b0;
      monitor_right_mute <= 1'b0;
      gain_code_reserved <= 1'b0;
    end
    else
    begin
      monitor_left_gain_code <= in_monitor ? left_steps : 7'h00;
      monitor_right_gain_code <= in_monitor ? right_steps : 7'h00;
      monitor_left_mute <= in_monitor && left_mute;
      monitor_right_mute <= in_monitor && right_mute;
      gain_code_reserved <= left_rsv || right_rsv;
    end
  end

  // Every enable rests off and the source select at line only outside playback-only operation, so no analog block wakes early.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      playback_line_input_mute <= 1'b0;
    end
    else
    begin
      playback_line_input_mute <= pbo_on && pbo_a_r[`BIT_LINE_MUTE];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      playback_left_opamp_enable <= 1'b0;
    end
    else
    begin
      playback_left_opamp_enable <= pbo_on && pbo_a_r[`BIT_LEFT_OPAMP];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      playback_right_opamp_enable <= 1'b0;
    end
    else
    begin
      playback_right_opamp_enable <= pbo_on && pbo_a_r[`BIT_RIGHT_OPAMP];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      headphone_amp_enable <= 1'b0;
    end
    else
    begin
      headphone_amp_enable <= pbo_on && pbo_b_r[`BIT_HPH_AMP];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      music_bypass_switch_on <= 1'b0;
    end
    else
    begin
      music_bypass_switch_on <= pbo_on &&
        (!pbo_b_r[`BIT_HPH_AMP] || !pbo_b_r[`BIT_PUMP]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      supply_pump_bypass_enable <= 1'b0;
    end
    else
    begin
      supply_pump_bypass_enable <= pbo_on && pbo_b_r[`BIT_PUMP_BYPASS];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mic_supply_regulator_enable <= 1'b0;
    end
    else
    begin
      mic_supply_regulator_enable <= pbo_on && pbo_b_r[`BIT_REGULATOR];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mic_supply_pump_enable <= 1'b0;
    end
    else
    begin
      mic_supply_pump_enable <= pbo_on && pbo_b_r[`BIT_PUMP];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mic_preamp_enable <= 1'b0;
    end
    else
    begin
      mic_preamp_enable <= pbo_on && pbo_b_r[`BIT_PREAMP];
    end
  end

  // The reserved source code would reach an absent path, so it falls back to line only.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      headphone_source_select <= `HPH_SRC_LINE_ONLY;
    end
    else if (!pbo_on || pbo_b_r[1:0] == `HPH_SRC_RESERVED)
    begin
      headphone_source_select <= `HPH_SRC_LINE_ONLY;
    end
    else
    begin
      headphone_source_select <= pbo_b_r[1:0];
    end
  end
endmodule

// ==== pkg/regbank_consts.svh ====
// Purpose: Offsets, field positions, reset values and codes of the mode control bank.
// Assumes: Printed offsets are register indices; byte address is four times the index.
// Notes: Definitions only.
`ifndef REGBANK_CONSTS_SVH
`define REGBANK_CONSTS_SVH
`define IDX_MON_LEFT_GAIN 8'h0F
`define IDX_MON_RIGHT_GAIN 8'h10
`define IDX_PBO_CTRL_A 8'h11
`define IDX_PBO_CTRL_B 8'h12
`define IDX_MODE_SELECT 8'h20
`define RST_MON_LEFT_GAIN 8'h57
`define RST_MON_RIGHT_GAIN 8'h57
`define RST_PBO_CTRL_A 8'h80
`define RST_PBO_CTRL_B 8'h1B
`define RST_MODE_SELECT 8'h00
`define MASK_GAIN 8'h7F
`define MASK_PBO_CTRL_A 8'hA3
`define MASK_PBO_CTRL_B 8'h7F
`define MASK_MODE_SELECT 8'h03
`define BIT_PBO_ENABLE 7
`define BIT_LINE_MUTE 5
`define BIT_LEFT_OPAMP 1
`define BIT_RIGHT_OPAMP 0
`define BIT_HPH_AMP 6
`define BIT_PUMP_BYPASS 5
`define BIT_REGULATOR 4
`define BIT_PUMP 3
`define BIT_PREAMP 2
`define GAIN_MAX_CODE 7'h3E
`define GAIN_RESERVED_CODE 7'h3F
`define GAIN_MUTE_NEG_ATT 7'h57
`define GAIN_MUTE_PLAIN 7'h7F
`define HPH_SRC_PREAMP 2'h0
`define HPH_SRC_OPAMP 2'h1
`define HPH_SRC_RESERVED 2'h2
`define HPH_SRC_LINE_ONLY 2'h3
`endif

// ==== pkg/regbank_pkg.sv ====
// Purpose: Types shared by the mode control bank.
// Assumes: Nothing beyond the constants header.
// Notes: Monitor and playback mode codes are one-hot; MODE_OTHER is zero.
package regbank_pkg;
  typedef enum logic [1:0] {
    MODE_OTHER = 2'h0,
    MODE_MONITOR = 2'h1,
    MODE_PLAYBACK = 2'h2
  } op_mode_t;
endpackage

// ==== core/gain_decode.sv ====
// Purpose: Turns a seven-bit gain code into half-decibel steps and a mute flag.
// Assumes: Code and the attenuation setting come from registers on the same clock.
// Notes: Combinational; callers register the results.
`include "regbank_consts.svh"
module gain_decode (
  input wire logic [6:0] code,
  input wire logic negative_attenuation_enable,
  output logic [6:0] half_db_steps,
  output logic mute,
  output logic reserved_code
);
  always_comb
  begin
    reserved_code = (code == `GAIN_RESERVED_CODE);
    mute = negative_attenuation_enable ? (code == `GAIN_MUTE_NEG_ATT) :
      (code == `GAIN_MUTE_PLAIN);
    if (mute || code > `GAIN_MAX_CODE)
    begin
      half_db_steps = 7'h00;
    end
    else
    begin
      half_db_steps = code;
    end
  end
endmodule

// ==== tb/mode_control_regs_assertions.sv ====
// Purpose: Port-level checks of the mode control bank.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Output checks tie fields to each other, since register contents are not visible.
module mode_control_regs_assertions #(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic pslverr,
  input wire logic [6:0] monitor_left_gain_code,
  input wire logic [6:0] monitor_right_gain_code,
  input wire logic monitor_left_mute,
  input wire logic monitor_right_mute,
  input wire logic playback_left_opamp_enable,
  input wire logic headphone_amp_enable,
  input wire logic music_bypass_switch_on,
  input wire logic mic_supply_pump_enable,
  input wire logic [1:0] headphone_source_select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_monitor_busy;
    monitor_left_mute || monitor_right_mute || (monitor_left_gain_code != 7'h00);
  endsequence
  a_err_in_access: assert property (pslverr |-> s_access)
    else $error("error flag outside an access");
  a_misalign_err: assert property ((s_access ##0 (paddr[1:0] != 2'h0)) |-> pslverr)
    else $error("misaligned access not refused");
  a_left_gain_range: assert property (monitor_left_gain_code <= 7'h3E)
    else $error("left gain beyond top step");
  a_right_gain_range: assert property (monitor_right_gain_code <= 7'h3E)
    else $error("right gain beyond top step");
  a_left_mute_zero: assert property (monitor_left_mute |->
    monitor_left_gain_code == 7'h00)
    else $error("left muted with gain");
  a_right_mute_zero: assert property (monitor_right_mute |->
    monitor_right_gain_code == 7'h00)
    else $error("right muted with gain");
  a_src_no_reserved: assert property (headphone_source_select != 2'h2)
    else $error("reserved source code driven");
  a_bypass_open: assert property (headphone_amp_enable && mic_supply_pump_enable
    |-> !music_bypass_switch_on)
    else $error("bypass on with amp and pump on");
  a_mode_exclusive: assert property (s_monitor_busy |->
    !(playback_left_opamp_enable || headphone_amp_enable))
    else $error("both modes driving");
endmodule
bind mode_control_regs mode_control_regs_assertions #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (
  .pclk, .presetn, .psel, .penable, .paddr, .pslverr, .monitor_left_gain_code,
  .monitor_right_gain_code, .monitor_left_mute, .monitor_right_mute,
  .playback_left_opamp_enable, .headphone_amp_enable, .music_bypass_switch_on,
  .mic_supply_pump_enable, .headphone_source_select
);

// ==== tb/mode_control_regs_bench.sv ====
// Purpose: Self-checking bench of the mode control bank over APB.
// Assumes: Byte address is four times the register index.
// Notes: Every wait on the bus is bounded by the cycle ceiling.
`include "regbank_consts.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
  $display("unexpected t=%0t got %h exp %h", $time, (a), (e)); end end
module mode_control_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_LG = 12'h03C, A_RG = 12'h040, A_CA = 12'h044, A_CB = 12'h048;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic negative_attenuation_enable = 1'b0, errflag;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, monitor_left_mute, monitor_right_mute, gain_code_reserved;
  logic [6:0] monitor_left_gain_code, monitor_right_gain_code;
  logic playback_line_input_mute, playback_left_opamp_enable, playback_right_opamp_enable;
  logic headphone_amp_enable, music_bypass_switch_on, supply_pump_bypass_enable;
  logic mic_supply_regulator_enable, mic_supply_pump_enable, mic_preamp_enable;
  logic [1:0] headphone_source_select;
  logic [15:0] tbl [7] = '{16'h0000, 16'h3E7C, 16'hD701, 16'h5700, 16'h7F01, 16'hFF00, 16'h3F00};
  int errors = 0, comparisons = 0, cyc = 0;
  wire logic [10:0] playback_only_mode = {playback_line_input_mute, playback_left_opamp_enable,
    playback_right_opamp_enable, headphone_amp_enable, music_bypass_switch_on,
    supply_pump_bypass_enable, mic_supply_regulator_enable, mic_supply_pump_enable,
    mic_preamp_enable, headphone_source_select};
  wire logic [16:0] mon = {monitor_left_mute, monitor_left_gain_code, monitor_right_mute,
    monitor_right_gain_code, gain_code_reserved};
  mode_control_regs dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .negative_attenuation_enable, .monitor_left_gain_code,
    .monitor_right_gain_code, .monitor_left_mute, .monitor_right_mute,
    .playback_line_input_mute, .playback_left_opamp_enable, .playback_right_opamp_enable,
    .headphone_amp_enable, .music_bypass_switch_on, .supply_pump_bypass_enable,
    .mic_supply_regulator_enable, .mic_supply_pump_enable, .mic_preamp_enable,
    .headphone_source_select, .gain_code_reserved);
  always #12.5 pclk = ~pclk;
  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // The request is held until pready is seen; read data and error are taken at that edge.
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    errflag = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 32'h0);
    `CHK(rd, {24'h0, e})
  endtask
  task automatic wset(input logic [11:0] a, input logic [7:0] d);
    xfer(a, 1'b1, {24'h0, d});
    repeat (2) @(posedge pclk);
    #1;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      conclude();
    end
  end
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    #1 `CHK(playback_only_mode, 11'h003)
    rchk(A_LG, `RST_MON_LEFT_GAIN);
    rchk(A_RG, 8'h57);
    rchk(A_CA, 8'h80);
    rchk(A_CB, 8'h1B);
    $display("test reset done");
    wset(A_CA, 8'hFF);
    rchk(A_CA, 8'hA3);
    wset(12'h080, {6'h0, regbank_pkg::MODE_PLAYBACK});
    `CHK(playback_only_mode, 11'h75B)
    wset(A_CB, 8'h7C);
    `CHK(playback_only_mode, 11'h7BC)
    wset(A_CB, 8'h74);
    `CHK(playback_only_mode, 11'h7F4)
    for (int i = 0; i < 4; i++)
    begin
      wset(A_CB, 8'h78 | 8'(i));
      `CHK(headphone_source_select, (i == 2) ? 2'h3 : 2'(i))
    end
    wset(A_CA, 8'h23);
    `CHK(playback_only_mode, 11'h003)
    $display("test playback done");
    wset(A_CA, 8'hA3);
    wset(12'h080, {6'h0, regbank_pkg::MODE_MONITOR});
    `CHK(playback_only_mode, 11'h003)
    for (int i = 0; i < 7; i++)
    begin
      @(posedge pclk) negative_attenuation_enable <= tbl[i][15];
      wset(A_LG, {1'b0, tbl[i][14:8]});
      wset(A_RG, {1'b0, tbl[i][14:8]});
      `CHK(mon, {tbl[i][0], tbl[i][7:1], tbl[i][0], tbl[i][7:1], tbl[i][14:8] == 7'h3F})
      rchk(A_RG, {1'b0, tbl[i][14:8]});
    end
    $display("test monitor done");
    @(posedge pclk) pstrb <= 4'hE;
    wset(A_LG, 8'h11);
    @(posedge pclk) pstrb <= 4'hF;
    rchk(A_LG, 8'h3F);
    wset(A_LG, 8'h22);
    `CHK(monitor_left_gain_code, 7'h22)
    wset(12'h080, 8'h03);
    `CHK(mon, 17'h00001)
    `CHK(playback_only_mode, 11'h003)
    rchk(12'h04C, 8'h00);
    `CHK(pready, 1'b1)
    `CHK(errflag, 1'b1)
    rchk(12'h03E, 8'h00);
    `CHK(errflag, 1'b1)
    $display("test refusal done");
    conclude();
  end
endmodule
